/* warn_alert_pkg.sv */
// Constants, carrier types and helper functions for the warning and alert block
// Overview of operation
// - Eight warning sources feed the status bits
// - Status bit sets on condition and stays latched
// - Clear command zeroes all bits; may set again
// - Alert pins released and disabled after reset
// - Per-output enables; any enabled warning asserts
// - Active level low, high when inverted
// - Outputs assert independently, release together
// - Persisting warning re-alerts on next sample after a clear
// - Alert response read at 0x0C; alerting devices answer
// - Own 7-bit address in upper bits of byte
// - Lowest address wins; losers keep alert asserted
// - Winner releases alert during the not-acknowledge bit
// - After win, re-alert only on new enabled bit
// - Comparator mode follows comparison live, unlatched
// - Comparator mode selection uses same enable bits
// - Aux low enable on output two alerts below limit
// - Readbacks and peaks return raw 12-bit codes
// - Clear command is send-byte code 0x03
// - Packet error checking on transactions and responses
package warn_alert_pkg;
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CONTROL = 8'h04;
    localparam logic [7:0] OFF_SETUP1 = 8'h08;
    localparam logic [7:0] OFF_SETUP2 = 8'h0C;
    localparam logic [7:0] OFF_OWN_ADDR = 8'h10;
    localparam logic [7:0] OFF_VIN = 8'h14;
    localparam logic [7:0] OFF_VAUX = 8'h18;
    localparam logic [7:0] OFF_IOUT = 8'h1C;
    localparam logic [7:0] OFF_PEAK_VIN = 8'h20;
    localparam logic [7:0] OFF_PEAK_VAUX = 8'h24;
    localparam logic [7:0] OFF_PEAK_IOUT = 8'h28;
    localparam logic [7:0] OFF_PIN_STATE = 8'h2C;

    localparam int W_COMM = 0;
    localparam int W_CURRENT_OVER = 1;
    localparam int W_VIN_LOW = 2;
    localparam int W_VIN_HIGH = 3;
    localparam int W_AUX_LOW = 4;
    localparam int W_AUX_HIGH = 5;
    localparam int W_POWER_OVER = 6;
    localparam int W_HYST = 7;
    localparam int CTRL_CLEAR_BIT = 0;
    localparam int SETUP_INVERT_BIT = 8;
    localparam int SETUP_MODE_BIT = 9;

    // Reset address value is arbitrary
    localparam logic [6:0] OWN_ADDR_RESET = 7'h40;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [6:0] ARA_ADDR = 7'h0C;
    localparam logic [7:0] CMD_CLEAR = 8'h03;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef struct packed {
        logic cmp_mode;
        logic invert;
        logic [7:0] enable;
    } output_setup_t;

    localparam output_setup_t SETUP_RESET = '0;

    typedef struct packed {
        logic valid;
        logic [7:0] cond;
        logic [11:0] vin;
        logic [11:0] vaux;
        logic [11:0] iout;
    } monitor_sample_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_RX = 3'b001,
        BUS_RX_ACK = 3'b011,
        BUS_TX = 3'b010,
        BUS_TX_ACK = 3'b110
    } bus_state_t;

    typedef struct packed {
        logic ahb_pend;
        logic ahb_wr;
        logic [7:0] ahb_addr;
        logic [31:0] rdata;
        logic [7:0] status;
        output_setup_t setup1;
        output_setup_t setup2;
        logic [6:0] own_addr;
        logic [11:0] vin;
        logic [11:0] vaux;
        logic [11:0] iout;
        logic [11:0] pk_vin;
        logic [11:0] pk_vaux;
        logic [11:0] pk_iout;
        logic [1:0] alert;
        logic [1:0] pin_oe;
        bus_state_t bst;
        logic scl_d;
        logic sda_d;
        logic [7:0] shreg;
        logic [3:0] bitcnt;
        logic [1:0] bytes;
        logic wr_mode;
        logic ara_mode;
        logic [7:0] crc;
        logic [7:0] cmd;
        logic pec_ok;
        logic pec_sent;
        logic ack;
        logic drive;
        logic ara_win;
    } state_t;

    function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    function automatic logic [11:0] peak12(input logic [11:0] held, input logic [11:0] code);
        return (code > held) ? code : held;
    endfunction
endpackage

/* pin_sync.sv */
// Two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1 <= '1;
            q <= '1;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule

/* warning_alert_logic.sv */
// Warning latches, alert outputs, SMBus clear and alert-response handling
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module warning_alert_logic (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire warn_alert_pkg::monitor_sample_t mon,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic first_multifunction_output_out,
    output logic first_multifunction_output_oe,
    output logic second_multifunction_output_out,
    output logic second_multifunction_output_oe
);
    import warn_alert_pkg::*;

    state_t s;
    state_t n;
    logic [1:0] pins_sync;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic clear_req;
    logic [7:0] set_bits;
    logic [7:0] newly;
    logic [7:0] live;
    logic release_all;
    logic accept;
    logic [31:0] rd;
    output_setup_t setup [2];

    pin_sync #(.WIDTH(2)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({scl_in, sda_in}),
        .q(pins_sync)
    );

    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];
    assign setup[0] = s.setup1;
    assign setup[1] = s.setup2;

    always_comb begin
        n = s;
        clear_req = 1'b0;
        set_bits = '0;
        rd = '0;
        scl_rise = scl_s & ~s.scl_d;
        scl_fall = ~scl_s & s.scl_d;
        start_cond = s.scl_d & scl_s & s.sda_d & ~sda_s;
        stop_cond = s.scl_d & scl_s & ~s.sda_d & sda_s;
        accept = hsel & htrans[1] & hready;
        n.scl_d = scl_s;
        n.sda_d = sda_s;
        n.ara_win = 1'b0;

        // Bus side: own-address clear and alert-response read
        if (start_cond) begin
            n.bst = BUS_RX;
            n.bitcnt = '0;
            n.bytes = '0;
            n.wr_mode = 1'b0;
            n.ara_mode = 1'b0;
            n.crc = '0;
            n.drive = 1'b0;
            n.pec_ok = 1'b0;
            n.pec_sent = 1'b0;
        end else if (stop_cond) begin
            // Command only acts at the stop, so a bad PEC can still veto it
            if (s.wr_mode && s.cmd == CMD_CLEAR && (s.bytes == 2'd2 ||
                    (s.bytes == 2'd3 && s.pec_ok))) begin
                clear_req = 1'b1;
            end
            n.bst = BUS_IDLE;
            n.drive = 1'b0;
            n.wr_mode = 1'b0;
            n.ara_mode = 1'b0;
        end else begin
            unique case (s.bst)
                BUS_IDLE: begin
                    n.drive = 1'b0;
                end
                BUS_RX: begin
                    if (scl_rise && s.bitcnt < BITS_PER_BYTE) begin
                        n.shreg = {s.shreg[6:0], sda_s};
                        n.bitcnt = s.bitcnt + 4'd1;
                    end else if (scl_fall && s.bitcnt == BITS_PER_BYTE) begin
                        n.crc = crc8(s.crc, s.shreg);
                        n.bitcnt = '0;
                        n.ack = 1'b1;
                        if (s.bytes == 2'd0) begin
                            if (s.shreg[7:1] == s.own_addr && !s.shreg[0]) begin
                                n.wr_mode = 1'b1;
                            end else if (s.shreg[7:1] == ARA_ADDR && s.shreg[0] &&
                                    |s.alert) begin
                                n.ara_mode = 1'b1;
                            end else begin
                                n.ack = 1'b0;
                            end
                        end else if (s.bytes == 2'd1) begin
                            n.cmd = s.shreg;
                            if (s.shreg != CMD_CLEAR) begin
                                n.ack = 1'b0;
                                set_bits[W_COMM] = 1'b1;
                            end
                        end else if (s.bytes == 2'd2) begin
                            n.pec_ok = (s.shreg == s.crc);
                            if (s.shreg != s.crc) begin
                                n.ack = 1'b0;
                                set_bits[W_COMM] = 1'b1;
                            end
                        end else begin
                            // Send-byte carries no data beyond the PEC
                            n.ack = 1'b0;
                            set_bits[W_COMM] = 1'b1;
                        end
                        if (s.bytes != 2'd3) begin
                            n.bytes = s.bytes + 2'd1;
                        end
                        n.drive = n.ack;
                        n.bst = n.ack ? BUS_RX_ACK : BUS_IDLE;
                    end
                end
                BUS_RX_ACK: begin
                    if (scl_fall) begin
                        if (s.ara_mode) begin
                            n.bst = BUS_TX;
                            n.shreg = {s.own_addr, 1'b1};
                            n.crc = crc8(s.crc, {s.own_addr, 1'b1});
                            n.bitcnt = '0;
                            n.drive = ~s.own_addr[6];
                        end else begin
                            n.bst = BUS_RX;
                            n.drive = 1'b0;
                        end
                    end
                end
                BUS_TX: begin
                    if (scl_rise) begin
                        // Released a one but line is low: a lower address won
                        if (!s.drive && !sda_s) begin
                            n.bst = BUS_IDLE;
                            n.drive = 1'b0;
                        end else begin
                            n.bitcnt = s.bitcnt + 4'd1;
                            n.shreg = {s.shreg[6:0], 1'b0};
                        end
                    end else if (scl_fall) begin
                        if (s.bitcnt == BITS_PER_BYTE) begin
                            n.drive = 1'b0;
                            n.ack = 1'b0;
                            n.bst = BUS_TX_ACK;
                        end else begin
                            n.drive = ~s.shreg[7];
                        end
                    end
                end
                BUS_TX_ACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            n.ara_win = 1'b1;
                            n.bst = BUS_IDLE;
                        end else begin
                            n.ack = 1'b1;
                        end
                    end else if (scl_fall && s.ack && !s.pec_sent) begin
                        n.pec_sent = 1'b1;
                        n.shreg = s.crc;
                        n.bitcnt = '0;
                        n.drive = ~s.crc[7];
                        n.ack = 1'b0;
                        n.bst = BUS_TX;
                    end
                end
                default: begin
                    n.bst = BUS_IDLE;
                    n.drive = 1'b0;
                end
            endcase
        end

        // Monitor samples: warnings and raw readbacks
        if (mon.valid) begin
            set_bits[7:1] = set_bits[7:1] | mon.cond[7:1];
            n.vin = mon.vin;
            n.vaux = mon.vaux;
            n.iout = mon.iout;
            n.pk_vin = peak12(s.pk_vin, mon.vin);
            n.pk_vaux = peak12(s.pk_vaux, mon.vaux);
            n.pk_iout = peak12(s.pk_iout, mon.iout);
        end

        // Register bus: write in data phase, read data captured at address phase
        if (s.ahb_pend && s.ahb_wr) begin
            unique case (s.ahb_addr)
                OFF_CONTROL: clear_req = clear_req | hwdata[CTRL_CLEAR_BIT];
                OFF_SETUP1: n.setup1 = hwdata[9:0];
                OFF_SETUP2: n.setup2 = hwdata[9:0];
                OFF_OWN_ADDR: n.own_addr = hwdata[6:0];
                default: ;
            endcase
        end
        unique case (haddr[7:0])
            OFF_STATUS: rd = {24'h000000, s.status};
            OFF_SETUP1: rd = {22'h000000, s.setup1};
            OFF_SETUP2: rd = {22'h000000, s.setup2};
            OFF_OWN_ADDR: rd = {25'h0000000, s.own_addr};
            OFF_VIN: rd = {20'h00000, s.vin};
            OFF_VAUX: rd = {20'h00000, s.vaux};
            OFF_IOUT: rd = {20'h00000, s.iout};
            OFF_PEAK_VIN: rd = {20'h00000, s.pk_vin};
            OFF_PEAK_VAUX: rd = {20'h00000, s.pk_vaux};
            OFF_PEAK_IOUT: rd = {20'h00000, s.pk_iout};
            OFF_PIN_STATE: rd = {28'h0000000, s.pin_oe, s.alert};
            default: rd = '0;
        endcase
        n.ahb_pend = accept;
        n.ahb_wr = hwrite;
        n.ahb_addr = haddr[7:0];
        if (accept && !hwrite) begin
            n.rdata = rd;
        end

        // Latched status: a set in the clearing cycle survives
        n.status = (clear_req ? STATUS_RESET : s.status) | set_bits;
        newly = set_bits & ~(clear_req ? STATUS_RESET : s.status);
        live = {mon.cond[7:1], s.status[W_COMM]};
        release_all = clear_req | s.ara_win;
        for (int o = 0; o < 2; o++) begin
            if (setup[o].cmp_mode) begin
                n.alert[o] = |(live & setup[o].enable);
            end else if (release_all) begin
                n.alert[o] = |(newly & setup[o].enable);
            end else begin
                n.alert[o] = s.alert[o] | (|(newly & setup[o].enable));
            end
            // Inverted pins sit pulled low and let go to show alert
            n.pin_oe[o] = setup[o].invert ^ n.alert[o];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.status <= STATUS_RESET;
            s.setup1 <= SETUP_RESET;
            s.setup2 <= SETUP_RESET;
            s.own_addr <= OWN_ADDR_RESET;
            s.bst <= BUS_IDLE;
            s.scl_d <= 1'b1;
            s.sda_d <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign hrdata = s.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign sda_out = 1'b0;
    assign sda_oe = s.drive;
    assign first_multifunction_output_out = 1'b0;
    assign first_multifunction_output_oe = s.pin_oe[0];
    assign second_multifunction_output_out = 1'b0;
    assign second_multifunction_output_oe = s.pin_oe[1];

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_latch_hold: assert property ((s.status & ~n.status) != 8'h00 |-> clear_req)
        else $error("status bit dropped without clear");
    chk_clear_zero: assert property (clear_req && set_bits == 8'h00 |=> s.status == 8'h00)
        else $error("clear left status bits set");
    chk_idle_released: assert property (!s.setup1.invert && s.setup1.enable == 8'h00 &&
            !s.setup1.cmp_mode && !s.alert[0] |=> !first_multifunction_output_oe)
        else $error("disabled output drives pin");
    chk_alert_raise: assert property (!s.setup2.cmp_mode &&
            (newly & s.setup2.enable) != 8'h00 |=> s.alert[1] && (second_multifunction_output_oe
            != s.setup2.invert))
        else $error("enabled warning did not raise alert");
    chk_release_both: assert property (release_all && newly == 8'h00 && !s.setup1.cmp_mode &&
            !s.setup2.cmp_mode |=> s.alert == 2'b00)
        else $error("alerts did not release together");
    chk_ara_release: assert property (s.bst == BUS_TX_ACK && scl_rise && sda_s &&
            !s.setup1.cmp_mode |=> s.alert[0] == $past(|(newly & s.setup1.enable)))
        else $error("winner kept alert");
    chk_cmp_live: assert property (s.setup1.cmp_mode |=>
            s.alert[0] == $past(|(live & s.setup1.enable)))
        else $error("comparator output not live");
    chk_readback_raw: assert property (mon.valid |=> s.vin == $past(mon.vin) &&
            s.iout == $past(mon.iout) && s.pk_vin >= s.vin)
        else $error("readback not raw code");
    chk_arb_loss: assert property (s.bst == BUS_TX && scl_rise && !s.drive && !sda_s |=>
            s.bst == BUS_IDLE && !sda_oe ##1 !s.ara_win)
        else $error("lost arbitration not abandoned");

    // Bus side and latch checks, plus further alert-path checks
    chk_status_set: assert property (mon.valid && mon.cond[W_VIN_LOW] |=>
            s.status[W_VIN_LOW])
        else $error("sampled warning not latched");
    chk_clear_release: assert property (clear_req && newly == 8'h00 &&
            !s.setup2.cmp_mode |=> !s.alert[1])
        else $error("clear did not release second output");
    chk_comm_error: assert property (s.bst == BUS_RX && scl_fall && s.bitcnt == BITS_PER_BYTE &&
            s.bytes == 2'd1 && s.shreg != CMD_CLEAR |=> s.status[W_COMM])
        else $error("bad command did not flag comm error");
    chk_ara_answer: assert property (s.bst == BUS_RX && scl_fall &&
            s.bitcnt == BITS_PER_BYTE && s.bytes == 2'd0 && s.shreg == {ARA_ADDR, 1'b1} &&
            (|s.alert) |=> s.ara_mode)
        else $error("alerting device ignored response address");
    chk_ara_addr: assert property (s.bst == BUS_RX_ACK && scl_fall && s.ara_mode |=>
            s.shreg == {$past(s.own_addr), 1'b1})
        else $error("response byte not own address");
    chk_idle_quiet: assert property (s.bst == BUS_IDLE |-> !sda_oe)
        else $error("idle bus side still drives data line");
    chk_pec_veto: assert property (stop_cond && s.wr_mode && s.bytes == 2'd3 && !s.pec_ok &&
            !(s.ahb_pend && s.ahb_wr) |-> !clear_req)
        else $error("clear taken despite bad check byte");
    chk_peak_hold: assert property (mon.valid |=> s.pk_iout >= $past(s.pk_iout))
        else $error("peak value dropped");
    chk_alert_hold: assert property (!s.setup1.cmp_mode && s.alert[0] && !release_all |=>
            s.alert[0])
        else $error("latched alert dropped without release");
    chk_cmp_two: assert property (s.setup2.cmp_mode |=>
            s.alert[1] == $past(|(live & s.setup2.enable)))
        else $error("second comparator output not live");
endmodule

/* smbus_host.sv */
// SMBus host controller model driving the clock line directly and the open-drain data line
`timescale 1ns/1ps
module smbus_host
    import warn_alert_pkg::*;
(
    output logic scl,
    output logic sda,
    input wire logic dev_pull
);
    import warn_alert_pkg::*;
    logic host_pull = 1'b0;
    initial scl = 1'b1;
    // Pull-up: a released line reads high
    assign sda = ~(host_pull | dev_pull);

    // Clock stands high between frames; data moves mid-low
    task automatic clk_bit(input logic pull, output logic b);
        #20 host_pull = pull;
        #20 scl = 1'b1;
        #20 b = sda;
        #20 scl = 1'b0;
    endtask

    task automatic start();
        host_pull = 1'b0;
        scl = 1'b1;
        #40 host_pull = 1'b1;
        #40 scl = 1'b0;
    endtask

    task automatic stop();
        #20 host_pull = 1'b1;
        #20 scl = 1'b1;
        #40 host_pull = 1'b0;
        #40;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic nack);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(~d[i], nack);
        end
        clk_bit(1'b0, nack);
    endtask

    // Send-byte: code only, no data follows
    task automatic send_cmd(input logic [6:0] a, input logic [7:0] code,
                            output logic [1:0] nacks);
        start();
        send_byte({a, 1'b0}, nacks[1]);
        send_byte(code, nacks[0]);
        stop();
    endtask

    // Receive byte at the response address; rival mimics a lower address
    task automatic ara(input logic rival, input logic [6:0] raddr,
                       output logic [7:0] d, output logic nack);
        logic [7:0] r;
        r = {raddr, 1'b1};
        start();
        send_byte({ARA_ADDR, 1'b1}, nack);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(rival & ~r[i], d[i]);
        end
        // Host answers with a not-acknowledge
        clk_bit(1'b0, r[0]);
    endtask
endmodule

/* testbench.sv */
// Self-checking bench for the warning latches and alert outputs
`timescale 1ns/1ps
module testbench;
    import warn_alert_pkg::*;
    localparam logic [7:0] B_VL = 8'h01 << W_VIN_LOW;
    localparam logic [7:0] B_VH = 8'h01 << W_VIN_HIGH;
    localparam logic [7:0] B_AL = 8'h01 << W_AUX_LOW;
    localparam logic [7:0] B_AH = 8'h01 << W_AUX_HIGH;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    monitor_sample_t mon = '0;
    logic scl;
    logic sda;
    logic sda_oe;
    logic o1_oe;
    logic o2_oe;
    logic [7:0] d;
    logic nk;
    logic [1:0] nacks;
    logic [31:0] x;
    int mismatches = 0;
    int num_checks = 0;

    always #5 hclk = ~hclk;

    warning_alert_logic dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mon(mon),
        .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .first_multifunction_output_out(), .first_multifunction_output_oe(o1_oe),
        .second_multifunction_output_out(), .second_multifunction_output_oe(o2_oe)
    );

    smbus_host host (.scl(scl), .sda(sda), .dev_pull(sda_oe));

    task complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One single word transfer; waits on hready under a bound
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
        x = hrdata;
        if (n >= 40) begin
            mismatches++;
            complete_run();
        end
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(x, exp);
        check({31'h0, hresp}, 32'h0);
    endtask

    // Mid-run reset must bring back the power-up status, setup and address values and released pins
    task t_rereset();
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        t_reset();
    endtask

    task sample(input logic [7:0] c);
        mon.valid <= 1'b1;
        mon.cond <= c;
        @(posedge hclk);
        mon.valid <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask

    // Look after the edge has settled, then realign
    task pins(input logic e1, input logic e2);
        #1;
        check({o1_oe, o2_oe}, {e1, e2});
        @(posedge hclk);
    endtask

    task t_reset();
        pins(1'b0, 1'b0);
        rd_chk(OFF_STATUS, {24'h0, STATUS_RESET});
        rd_chk(OFF_SETUP1, 32'h0);
        rd_chk(OFF_SETUP2, 32'h0);
        rd_chk(OFF_OWN_ADDR, {25'h0, OWN_ADDR_RESET});
        rd_chk(8'h30, 32'h0);
    endtask

    task t_latch();
        ahb(1'b1, OFF_SETUP1, {24'h0, B_VL});
        ahb(1'b1, OFF_SETUP2, {24'h0, B_AL | B_VH});
        sample(B_VL);
        pins(1'b1, 1'b0);
        sample(8'h00);
        rd_chk(OFF_STATUS, {24'h0, B_VL});
        pins(1'b1, 1'b0);
        sample(B_AL);
        pins(1'b1, 1'b1);
        rd_chk(OFF_STATUS, {24'h0, B_VL | B_AL});
    endtask

    task t_clear_ahb();
        ahb(1'b1, OFF_CONTROL, 32'h1);
        repeat (2) @(posedge hclk);
        pins(1'b0, 1'b0);
        rd_chk(OFF_STATUS, 32'h0);
        sample(B_AL);
        pins(1'b0, 1'b1);
    endtask

    task t_smbus();
        host.send_cmd(OWN_ADDR_RESET, CMD_CLEAR, nacks);
        check(nacks, 2'b00);
        repeat (5) @(posedge hclk);
        pins(1'b0, 1'b0);
        rd_chk(OFF_STATUS, 32'h0);
        host.send_cmd(OWN_ADDR_RESET, 8'h05, nacks);
        check(nacks, 2'b01);
        repeat (5) @(posedge hclk);
        rd_chk(OFF_STATUS, 32'h1 << W_COMM);
        ahb(1'b1, OFF_CONTROL, 32'h1);
    endtask

    task t_ara();
        sample(B_AL);
        host.ara(1'b1, 7'h20, d, nk);
        host.stop();
        check({nk, d}, {1'b0, 7'h20, 1'b1});
        pins(1'b0, 1'b1);
        host.ara(1'b0, 7'h00, d, nk);
        check({nk, d[7:1]}, {1'b0, OWN_ADDR_RESET});
        repeat (4) @(posedge hclk);
        pins(1'b0, 1'b0);
        host.stop();
        @(posedge hclk);
        rd_chk(OFF_STATUS, {24'h0, B_AL});
        sample(B_AL);
        pins(1'b0, 1'b0);
        sample(B_AL | B_VH);
        pins(1'b0, 1'b1);
    endtask

    // Comparator follows the live condition with no latch
    task t_comparator();
        ahb(1'b1, OFF_CONTROL, 32'h1);
        ahb(1'b1, OFF_SETUP1, 32'h200 | {24'h0, B_AH});
        mon.cond <= B_AH;
        repeat (3) @(posedge hclk);
        pins(1'b1, 1'b0);
        mon.cond <= 8'h00;
        repeat (3) @(posedge hclk);
        pins(1'b0, 1'b0);
    endtask

    // Open drain cannot drive high: inverted idle pulls, active releases
    task t_invert();
        ahb(1'b1, OFF_SETUP1, 32'h100 | {24'h0, B_VL});
        repeat (2) @(posedge hclk);
        pins(1'b1, 1'b0);
        sample(B_VL);
        pins(1'b0, 1'b0);
        ahb(1'b1, OFF_SETUP1, 32'h0);
        ahb(1'b1, OFF_CONTROL, 32'h1);
    endtask

    task t_readback();
        mon.vin <= 12'hABC;
        mon.iout <= 12'h7FF;
        sample(8'h00);
        rd_chk(OFF_VIN, 32'hABC);
        rd_chk(OFF_IOUT, 32'h7FF);
        mon.vin <= 12'h123;
        sample(8'h00);
        rd_chk(OFF_VIN, 32'h123);
        rd_chk(OFF_PEAK_VIN, 32'hABC);
    endtask

    initial begin
        #500000;
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        t_reset();
        t_latch();
        t_clear_ahb();
        t_smbus();
        t_ara();
        t_comparator();
        t_invert();
        t_readback();
        t_rereset();
        complete_run();
    end
endmodule
